// ### tpg_port.sv
// two-pin general-purpose port with register access and standby control
//
// How it works
// - direction bit 1 makes the pin an output.
// - an output pin drives the latch bit.
// - latch writes appear on output pins one cycle after the latch register updates.
// - reads of output pins return the latch bit.
// - direction bit 0 makes the pin an input.
// - latch writes on input pins are stored but not driven.
// - plain reads of input pins give the pin; rmw reads give the latch.
// - input reads give the pin level even when a peripheral uses it.
// - reset clears all direction bits so pins start as inputs.
// - standby with pin-state bit 1: hi-z, input held low and blocked.
// - standby with pin-state bit 0: previous drive and level held.
// - standby with pin-state bit 0: state kept, input gate blocked.
// - pull-up bit 1 connects the pull-up, 0 disconnects it.
// - a pin driving low never has its pull-up connected.
// - only bits 1 and 2 exist; other bits have no pin.
// - during reset pins are hi-z with the gated input held low.
// - input blocked cuts the direct input path into the logic.
// - in hi-z standby the pull-up setting still applies.
// - standby states hold for pins used as port, not oscillator; reset states hold for both.
`include "tpg_regs.svh"
module tpg_port (
  input  wire logic                   clk,           // 25 mhz system clock
  input  wire logic                   rst_n,         // sync reset, active low
  input  wire logic [`TPG_ADDR_W-1:0] addr,          // register address
  input  wire logic [7:0]             wdata,         // write data
  input  wire logic                   wr,            // write strobe
  input  wire logic                   rd,            // read strobe
  output logic      [7:0]             rdata,         // read data, next cycle
  input  wire logic                   standby_pin_state_bit, // hi-z select
  input  wire logic                   stop_watch,    // stop or watch mode
  input  wire logic [2:1]             osc_select,    // pin used as oscillator
  input  wire logic [2:1]             pin_in,        // pin levels
  output logic      [2:1]             pin_out,       // pin drive values
  output logic      [2:1]             pin_oe,        // pin drive enables
  output logic      [2:1]             pin_pullup,    // pull-up connected
  output logic      [2:1]             pin_gated_in,  // to trigger inputs
  output logic      [2:1]             osc_in         // raw to oscillator
);
  localparam int PIN_LO = `TPG_PIN_LO;
  localparam int PIN_HI = `TPG_PIN_HI;

  logic [7:0] port_output_latch_reg;
  logic [7:0] port_direction_reg;
  logic [7:0] port_pullup_enable_reg;
  logic [7:0] rdata_next;
  logic [7:0] pin_level;
  tpg_pkg::tpg_pin_mode_type mode [2:1];

  ////////////////////////////////////////////////////////////////////////
  // register writes

  always_ff @(posedge clk) begin
    if (!rst_n)
      port_output_latch_reg <= `TPG_RST_LATCH;
    else if (wr && addr == `TPG_OFS_LATCH)
      port_output_latch_reg <= wdata & `TPG_PIN_MASK;
  end

  always_ff @(posedge clk) begin
    if (!rst_n)
      port_direction_reg <= `TPG_RST_DIR;
    else if (wr && addr == `TPG_OFS_DIR)
      port_direction_reg <= wdata & `TPG_PIN_MASK;
  end

  always_ff @(posedge clk) begin
    if (!rst_n)
      port_pullup_enable_reg <= `TPG_RST_PULLUP;
    else if (wr && addr == `TPG_OFS_PULLUP)
      port_pullup_enable_reg <= wdata & `TPG_PIN_MASK;
  end

  ////////////////////////////////////////////////////////////////////////
  // register reads

  always_comb begin
    pin_level = 8'h00;
    pin_level[PIN_HI:PIN_LO] = pin_in;
  end

  always_comb begin
    case (addr)
      `TPG_OFS_LATCH:
        // output pins read the latch, input pins the pin
        rdata_next = (port_output_latch_reg & port_direction_reg)
                   | (pin_level & ~port_direction_reg
                      & `TPG_PIN_MASK);
      `TPG_OFS_RMW_READ:
        rdata_next = port_output_latch_reg;
      `TPG_OFS_DIR:
        rdata_next = port_direction_reg;
      `TPG_OFS_PULLUP:
        rdata_next = port_pullup_enable_reg;
      `TPG_OFS_STATUS: begin
        rdata_next = 8'h00;
        rdata_next[PIN_HI:PIN_LO] = pin_oe;
      end
      default:
        rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n)
      rdata <= 8'h00;
    else if (rd)
      rdata <= rdata_next;
    else
      rdata <= 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////
  // per-pin standby mode and pin cells

  generate
    for (genvar i = PIN_LO; i <= PIN_HI; i++) begin : g_pin
      always_comb begin
        if (!stop_watch || osc_select[i])
          mode[i] = tpg_pkg::tpg_run;
        else if (standby_pin_state_bit)
          mode[i] = tpg_pkg::tpg_hiz;
        else
          mode[i] = tpg_pkg::tpg_hold;
      end

      tpg_pin_cell u_cell (
        .clk       (clk),
        .rst_n     (rst_n),
        .mode      (mode[i]),
        .latch_bit (port_output_latch_reg[i]),
        .dir_bit   (port_direction_reg[i] && !osc_select[i]),
        .pull_bit  (port_pullup_enable_reg[i]),
        .pin_in    (pin_in[i]),
        .pin_out   (pin_out[i]),
        .pin_oe    (pin_oe[i]),
        .pull_en   (pin_pullup[i]),
        .in_gated  (pin_gated_in[i])
      );

      // oscillator sees the raw pin; only gated path is blocked
      always_ff @(posedge clk) begin
        if (!rst_n)
          osc_in[i] <= 1'b0;
        else
          osc_in[i] <= pin_in[i] && osc_select[i];
      end
    end
  endgenerate
endmodule

// ### tpg_regs.svh
// register offsets, field positions, reset values and widths for the port
`ifndef TPG_REGS_SVH
`define TPG_REGS_SVH

`define TPG_ADDR_W        4
`define TPG_OFS_LATCH     4'h0
`define TPG_OFS_DIR       4'h1
`define TPG_OFS_PULLUP    4'h2
`define TPG_OFS_RMW_READ  4'h3
`define TPG_OFS_STATUS    4'h4
`define TPG_PIN_LO        1
`define TPG_PIN_HI        2
`define TPG_PIN_MASK      8'h06
`define TPG_RST_LATCH     8'h00
`define TPG_RST_DIR       8'h00
`define TPG_RST_PULLUP    8'h00

`endif

// ### tpg_pkg.sv
// types shared by the two-pin port files
package tpg_pkg;
  typedef enum logic [1:0] {
    tpg_run,
    tpg_hold,
    tpg_hiz
  } tpg_pin_mode_type;
endpackage

// ### tpg_pin_cell.sv
// one pin: drive, pull-up and input gate under the standby mode
module tpg_pin_cell (
  input  wire logic                   clk,        // system clock
  input  wire logic                   rst_n,      // sync reset, active low
  input  wire tpg_pkg::tpg_pin_mode_type mode,    // run, hold or hi-z
  input  wire logic                   latch_bit,  // output latch bit
  input  wire logic                   dir_bit,    // 1 = output
  input  wire logic                   pull_bit,   // pull-up enable bit
  input  wire logic                   pin_in,     // pin level
  output logic                        pin_out,    // pin drive value
  output logic                        pin_oe,     // pin drive enable
  output logic                        pull_en,    // pull-up connected
  output logic                        in_gated    // gated input value
);
  logic drv_val;
  logic drv_en;

  always_comb begin
    case (mode)
      tpg_pkg::tpg_run: begin
        drv_val = latch_bit;
        drv_en  = dir_bit;
      end
      tpg_pkg::tpg_hold: begin
        drv_val = pin_out;
        drv_en  = pin_oe;
      end
      tpg_pkg::tpg_hiz: begin
        drv_val = 1'b0;
        drv_en  = 1'b0;
      end
      default: begin
        drv_val = 1'b0;
        drv_en  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_out <= 1'b0;
      pin_oe  <= 1'b0;
    end else begin
      pin_out <= drv_val;
      pin_oe  <= drv_en;
    end
  end

  // pull-up survives hi-z standby, but never fights a driven low
  always_ff @(posedge clk) begin
    if (!rst_n)
      pull_en <= 1'b0;
    else
      pull_en <= pull_bit && !(drv_en && !drv_val);
  end

  // blocked input reads as low to stop leakage from a floating pin
  always_ff @(posedge clk) begin
    if (!rst_n)
      in_gated <= 1'b0;
    else if (mode != tpg_pkg::tpg_run)
      in_gated <= 1'b0;
    else
      in_gated <= pin_in;
  end
endmodule

// ### tpg_port_monitor.sv
// checker for the two-pin port, bound onto its ports
`include "tpg_regs.svh"
module tpg_port_monitor (
  input wire logic       clk,                   // clock
  input wire logic       rst_n,                 // sync reset
  input wire logic [3:0] addr,                  // address
  input wire logic [7:0] wdata,                 // write data
  input wire logic       wr,                    // write strobe
  input wire logic       rd,                    // read strobe
  input wire logic [7:0] rdata,                 // read data
  input wire logic       standby_pin_state_bit, // hi-z pick
  input wire logic       stop_watch,            // standby
  input wire logic [2:1] pin_in,                // pin level
  input wire logic [2:1] pin_out,               // drive value
  input wire logic [2:1] pin_oe,                // drive enable
  input wire logic [2:1] pin_pullup,            // pull-up on
  input wire logic [2:1] pin_gated_in,          // gated input
  input wire logic [2:1] osc_select             // oscillator pins
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  chk_reset_quiet: assert property (
    $rose(rst_n) |-> !pin_oe && !rdata) else $error("pins on after reset");
  // oscillator pins keep running in standby, so only port pins are held
  chk_hiz_pins: assert property (
    standby_pin_state_bit && stop_watch && osc_select == 2'h0
    |=> !pin_oe && !pin_gated_in) else $error("standby hi-z missed");
  chk_hold_drive: assert property (
    stop_watch && !standby_pin_state_bit && osc_select == 2'h0
    |=> $stable(pin_oe) && $stable(pin_out) && !pin_gated_in)
    else $error("held state moved");
  chk_pull_low: assert property (
    (pin_pullup & pin_oe & ~pin_out) == 2'h0) else $error("pull-up on low");
  chk_read_idle: assert property (
    !rd |=> rdata == 8'h00) else $error("read data outside slot");
  chk_read_mask: assert property (
    rd |=> rdata[7:3] == 5'h00 && !rdata[0]) else $error("unused bit set");
  chk_input_path: assert property (
    !stop_watch |=> pin_gated_in == $past(pin_in)) else $error("input lost");
  // any write in the next cycle is excluded, though a direction write there reaches pin_oe only after the check
  chk_dir_write: assert property (
    wr && addr == `TPG_OFS_DIR
    ##1 !stop_watch && !wr && osc_select == 2'h0
    |=> pin_oe == $past(wdata[2:1], 2)) else $error("direction not applied");
  cover property (standby_pin_state_bit && stop_watch);
  cover property (stop_watch && !standby_pin_state_bit);
  cover property (rd ##1 rdata != 8'h00);
  cover property (stop_watch && osc_select != 2'h0);
endmodule
bind tpg_port tpg_port_monitor u_mon (.clk, .rst_n, .addr, .wdata, .wr,
  .rd, .rdata, .standby_pin_state_bit, .stop_watch, .pin_in, .pin_out,
  .pin_oe, .pin_pullup, .pin_gated_in, .osc_select);

// ### tpg_pins_model.sv
// board side of the two port pins: drivers, pull-ups, floating lines
module tpg_pins_model (
  input  wire logic       clk,        // clock for the floating pattern
  input  wire logic [2:1] pin_out,    // port drive value
  input  wire logic [2:1] pin_oe,     // port drive enable
  input  wire logic [2:1] pin_pullup, // pull-up connected
  input  wire logic [2:1] ext_en,     // board driver enable
  input  wire logic [2:1] ext_val,    // board driver level
  output logic      [2:1] pin_lvl     // resolved pin level
);
  timeunit 1ns;
  timeprecision 1ns;
  logic tog = 1'h0;
  // a floating pin flips each cycle so a stale level never looks valid
  always @(posedge clk) tog <= ~tog;
  // no peripheral output drives the pins here
  assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
    | (~pin_oe & ~ext_en & (pin_pullup | {2{tog}}));
endmodule

// ### tpg_port_tb_top.sv
// self-checking bench for the two-pin port
`include "tpg_regs.svh"
module tpg_port_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 1'h0, rst_n = 1'h0, wr = 1'h0, rd = 1'h0;
  logic       hiz_sel = 1'h0, stop_watch = 1'h0;
  logic [2:1] osc_sel = 2'h0, oscin;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata;
  logic [2:1] ext_en = 2'h3, ext_val = 2'h2, pin_lvl, pout, poe, ppu, pgi;
  int         errors = 0, comparisons = 0, cyc = 0;
  tpg_port u_dut (.clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata,
    .standby_pin_state_bit(hiz_sel), .stop_watch, .osc_select(osc_sel),
    .pin_in(pin_lvl), .pin_out(pout), .pin_oe(poe), .pin_pullup(ppu),
    .pin_gated_in(pgi), .osc_in(oscin));
  tpg_pins_model u_pins (.clk, .pin_out(pout), .pin_oe(poe),
    .pin_pullup(ppu), .ext_en, .ext_val, .pin_lvl);
  initial forever #20 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic ck(input logic ok, input string m);
    comparisons++;
    if (!ok) begin
      errors++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= w;
    rd    <= !w;
    @(posedge clk);
    wr <= 1'h0;
    rd <= 1'h0;
    #1 if (!w) ck(rdata === d, "read data");
  endtask
  // pins are registered, so two edges let every update land
  task automatic pchk(input logic [2:1] oe, o, pu, gi);
    repeat (2) @(posedge clk);
    #1 ck({poe, pout & poe, ppu, pgi} === {oe, o, pu, gi}, "pin state");
  endtask
  task automatic wrap_up;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      errors++;
      wrap_up();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'h1;
    acc(1'h0, `TPG_OFS_DIR, 8'h00);
    pchk(2'h0, 2'h0, 2'h0, 2'h2);
    $display("test reset done");
    acc(1'h1, `TPG_OFS_LATCH, 8'hff);
    pchk(2'h0, 2'h0, 2'h0, 2'h2);
    acc(1'h0, `TPG_OFS_LATCH, 8'h04);
    acc(1'h0, `TPG_OFS_RMW_READ, 8'h06);
    acc(1'h0, 4'hf, 8'h00);
    $display("test input done");
    acc(1'h1, `TPG_OFS_PULLUP, 8'hff);
    acc(1'h1, `TPG_OFS_DIR, 8'h02);
    // pin two is let go so only the pull-up holds it high
    @(posedge clk) begin
      ext_en  <= 2'h1;
      ext_val <= 2'h0;
    end
    pchk(2'h1, 2'h1, 2'h3, 2'h3);
    acc(1'h0, `TPG_OFS_LATCH, 8'h06);
    acc(1'h0, `TPG_OFS_STATUS, 8'h02);
    acc(1'h1, `TPG_OFS_LATCH, 8'h00);
    pchk(2'h1, 2'h0, 2'h2, 2'h2);
    $display("test output done");
    acc(1'h1, `TPG_OFS_LATCH, 8'h02);
    @(posedge clk) stop_watch <= 1'h1;
    acc(1'h1, `TPG_OFS_LATCH, 8'h00);
    pchk(2'h1, 2'h1, 2'h3, 2'h0);
    // a high board level on pin one must still read as blocked
    @(posedge clk) begin
      hiz_sel <= 1'h1;
      ext_val <= 2'h3;
    end
    pchk(2'h0, 2'h0, 2'h3, 2'h0);
    @(posedge clk) stop_watch <= 1'h0;
    pchk(2'h1, 2'h0, 2'h2, 2'h2);
    $display("test standby done");
    @(posedge clk) osc_sel <= 2'h2;
    repeat (2) @(posedge clk);
    #1 ck({poe, oscin} === 4'h6, "oscillator pin");
    @(posedge clk) stop_watch <= 1'h1;
    repeat (2) @(posedge clk);
    #1 ck({poe, oscin} === 4'h2, "oscillator standby");
    $display("test oscillator done");
    @(posedge clk) begin
      stop_watch <= 1'h0;
      osc_sel    <= 2'h0;
      rst_n      <= 1'h0;
    end
    repeat (2) @(posedge clk);
    #1 ck({poe, ppu, pgi, oscin, rdata} === 16'h0000, "reset pins");
    @(posedge clk) rst_n <= 1'h1;
    acc(1'h0, `TPG_OFS_DIR, 8'h00);
    acc(1'h0, `TPG_OFS_RMW_READ, 8'h00);
    $display("test second reset done");
    wrap_up();
  end
endmodule
